// ---- hw/dbg_sync_pkg.sv ----
// shared constants and types for the debug pc-sync block
package dbg_sync_pkg;
    localparam int CLK_PERIOD_NS = 100;
    localparam int FAST_BASE_CYCLES = 128;
    localparam int SLOW_BASE_CYCLES = 2048;
    localparam int TRACE_FIFO_DEPTH = 16;
    localparam int TRACE_WIDTH = 8;
    localparam int DEBUG_EXTENDED_CONTROL_STATUS_ENABLE_BIT = 0;
    localparam int DEBUG_EXTENDED_CONTROL_STATUS_SELECT_LSB = 1;
    localparam int DEBUG_CONFIG_STATUS_SECOND_DIV16_BIT = 6;
    localparam int DEBUG_CONFIG_STATUS_SECOND_TOP_LSB = 24;
    localparam logic [31:0] DEBUG_EXTENDED_CONTROL_STATUS_RESET = 32'h0000_0000;
    localparam logic [31:0] DEBUG_EXTENDED_CONTROL_STATUS_WRITE_MASK = 32'h0000_0007;
    localparam logic [31:0] DEBUG_CONFIG_STATUS_SECOND_RESET = 32'h0001_0000;
    localparam logic [31:0] DEBUG_CONFIG_STATUS_SECOND_HOST_MASK = 32'h3BFF_FFFF;
    localparam logic [31:0] DEBUG_CONFIG_STATUS_SECOND_CORE_MASK = 32'h00FF_FFFF;
    localparam logic [7:0] MARK_ADDR2 = 8'h0D;
    localparam logic [7:0] MARK_ADDR3 = 8'h0E;

    typedef enum logic [2:0] {
        CMD_NONE = 3'h0,
        CMD_READ_TOP_BYTE = 3'h1,
        CMD_WRITE_TOP_BYTE = 3'h2,
        CMD_READ_DEBUG_REGISTER_CMD = 3'h3,
        CMD_WRITE_DEBUG_REGISTER_CMD = 3'h4
    } host_cmd_t;

    typedef enum logic {
        REG_DEBUG_EXTENDED_CONTROL_STATUS = 1'b0,
        REG_DEBUG_CONFIG_STATUS_SECOND = 1'b1
    } reg_sel_t;

    typedef enum logic [2:0] {
        TR_IDLE = 3'b000,
        TR_MARK = 3'b001,
        TR_ADR0 = 3'b011,
        TR_ADR1 = 3'b010,
        TR_ADR2 = 3'b110
    } trace_state_t;
endpackage

// ---- hw/trace_stream_if.sv ----
// valid/ready stream between the trace packer and its fifo
interface trace_stream_if #(parameter int WIDTH = 8);
    logic inValid;
    logic inReady;
    logic [WIDTH-1:0] inData;
    logic outValid;
    logic outReady;
    logic [WIDTH-1:0] outData;
    modport fifo (input inValid, inData, outReady,
                  output inReady, outValid, outData);
    modport user (output inValid, inData, outReady,
                  input inReady, outValid, outData);
endinterface

// ---- hw/trace_fifo.sv ----
// trace byte fifo with registered read data
module trace_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input wire logic clk_sys,
    input wire logic reset,
    trace_stream_if.fifo s
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL_COUNT = (AW+1)'(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wrPtr_q;
    logic [AW-1:0] rdPtr_q;
    logic [AW:0] count_q;
    logic outValid_q;
    logic [WIDTH-1:0] outData_q;
    wire doPush;
    wire doPop;
    wire memEmpty;

    // push when room, refill output register when free
    assign memEmpty = (count_q == '0);
    assign s.inReady = (count_q != FULL_COUNT);
    assign doPush = s.inValid && s.inReady;
    assign doPop = !memEmpty && (!outValid_q || s.outReady);
    assign s.outValid = outValid_q;
    assign s.outData = outData_q;

    // storage array, no reset needed
    always_ff @(posedge clk_sys) begin
        if (doPush) begin
            mem[wrPtr_q] <= s.inData;
        end
    end

    // pointers, count and output stage
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            wrPtr_q <= '0;
            rdPtr_q <= '0;
            count_q <= '0;
            outValid_q <= 1'b0;
            outData_q <= '0;
        end else begin
            if (doPush) wrPtr_q <= wrPtr_q + 1'b1;
            if (doPop) rdPtr_q <= rdPtr_q + 1'b1;
            count_q <= count_q + (AW+1)'(doPush) - (AW+1)'(doPop);
            if (doPop) begin
                outData_q <= mem[rdPtr_q];
                outValid_q <= 1'b1;
            end else if (s.outReady) begin
                outValid_q <= 1'b0;
            end
        end
    end
endmodule

// ---- hw/debug_pc_sync.sv ----
// periodic pc sync, trace address packer and second config register
module debug_pc_sync
    import dbg_sync_pkg::*;
#(
    parameter int FAST_BASE = dbg_sync_pkg::FAST_BASE_CYCLES,
    parameter int SLOW_BASE = dbg_sync_pkg::SLOW_BASE_CYCLES,
    parameter int FIFO_DEPTH = dbg_sync_pkg::TRACE_FIFO_DEPTH
) (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic hostCmdValid,
    input wire dbg_sync_pkg::host_cmd_t hostCmd,
    input wire dbg_sync_pkg::reg_sel_t hostRegSel,
    input wire logic [31:0] hostWrData,
    output logic hostRdValid,
    output logic [31:0] hostRdData,
    input wire logic coreDebugWrite,
    input wire logic coreSupervisor,
    input wire logic [31:0] coreWrData,
    input wire logic cfgAddrWide,
    output logic syncRequest,
    input wire logic forcedFetchValid,
    input wire logic [23:0] forcedFetchAddr,
    output logic traceValid,
    output logic [7:0] traceData,
    input wire logic traceReady
);
    import dbg_sync_pkg::*;

    localparam int CW = $clog2(SLOW_BASE * 8);

    // period of the sync timer for a divide flag and select code
    function automatic logic [CW:0] periodOf(input logic div16,
                                             input logic [1:0] sel);
        logic [CW:0] base;
        base = div16 ? (CW+1)'(FAST_BASE) : (CW+1)'(SLOW_BASE);
        return base << sel;
    endfunction

    logic [31:0] debug_extended_control_status_q;
    logic [31:0] debug_config_status_second_q;
    logic [31:0] debug_config_status_second_d;
    logic [31:0] debug_extended_control_status_d;
    logic hostRdValid_q;
    logic [31:0] hostRdData_q;
    logic syncReq_q;
    logic enablePrev_q;
    logic [CW:0] timer_q;
    trace_state_t state_q;
    trace_state_t state_d;
    logic [23:0] addr_q;
    logic wide_q;

    trace_stream_if #(.WIDTH(TRACE_WIDTH)) tq ();

    // decoded control fields
    wire syncEnable = debug_extended_control_status_q[DEBUG_EXTENDED_CONTROL_STATUS_ENABLE_BIT];
    wire [1:0] syncSel = debug_extended_control_status_q[DEBUG_EXTENDED_CONTROL_STATUS_SELECT_LSB +: 2];
    wire syncDiv16 = debug_config_status_second_q[DEBUG_CONFIG_STATUS_SECOND_DIV16_BIT];
    wire [CW:0] period = periodOf(syncDiv16, syncSel);
    wire enableRise = syncEnable && !enablePrev_q;
    wire expiry = syncEnable && !enableRise
                  && (timer_q == period - 1'b1);

    // host command decode
    wire isCsr2 = (hostRegSel == REG_DEBUG_CONFIG_STATUS_SECOND);
    wire byteRead = hostCmdValid && (hostCmd == CMD_READ_TOP_BYTE);
    wire byteWrite = hostCmdValid && (hostCmd == CMD_WRITE_TOP_BYTE);
    wire dregRead = hostCmdValid && (hostCmd == CMD_READ_DEBUG_REGISTER_CMD);
    wire dregWrite = hostCmdValid && (hostCmd == CMD_WRITE_DEBUG_REGISTER_CMD);
    wire coreWrite = coreDebugWrite && coreSupervisor;
    wire anyRead = byteRead || dregRead;

    // read data: top byte alone or the whole word
    wire [31:0] readWord = isCsr2 ? debug_config_status_second_q : debug_extended_control_status_q;
    wire [31:0] byteWord = {24'h00_0000, debug_config_status_second_q[31:24]};
    wire [31:0] rdSel = byteRead ? byteWord : readWord;

    // next value of the second config register
    wire [31:0] byteMerge = {hostWrData[7:0], 24'h00_0000};
    wire [31:0] byteMask = {8'hFF, 24'h00_0000} & DEBUG_CONFIG_STATUS_SECOND_HOST_MASK;
    wire [31:0] coreMerge = (debug_config_status_second_q & ~DEBUG_CONFIG_STATUS_SECOND_CORE_MASK)
                            | (coreWrData & DEBUG_CONFIG_STATUS_SECOND_CORE_MASK);
    wire [31:0] csr2Base = coreWrite ? coreMerge : debug_config_status_second_q;

    // a host register write replaces a core write in the same cycle; a top byte write merges with it
    always_comb begin
        debug_config_status_second_d = csr2Base;
        if (byteWrite) begin
            debug_config_status_second_d = (csr2Base & ~byteMask)
                     | (byteMerge & byteMask);
        end else if (dregWrite && isCsr2) begin
            debug_config_status_second_d = hostWrData & DEBUG_CONFIG_STATUS_SECOND_HOST_MASK;
        end
    end

    // next value of the extended control register
    assign debug_extended_control_status_d = (dregWrite && !isCsr2)
                    ? (hostWrData & DEBUG_EXTENDED_CONTROL_STATUS_WRITE_MASK) : debug_extended_control_status_q;

    // register file and read answer
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            debug_extended_control_status_q <= DEBUG_EXTENDED_CONTROL_STATUS_RESET;
            debug_config_status_second_q <= DEBUG_CONFIG_STATUS_SECOND_RESET;
            hostRdValid_q <= 1'b0;
            hostRdData_q <= '0;
        end else begin
            debug_extended_control_status_q <= debug_extended_control_status_d;
            debug_config_status_second_q <= debug_config_status_second_d;
            hostRdValid_q <= anyRead;
            hostRdData_q <= anyRead ? rdSel : hostRdData_q;
        end
    end

    // sync timer and request pulse
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            timer_q <= '0;
            enablePrev_q <= 1'b0;
            syncReq_q <= 1'b0;
        end else begin
            enablePrev_q <= syncEnable;
            syncReq_q <= expiry;
            if (!syncEnable || enableRise || expiry) begin
                timer_q <= '0;
            end else begin
                timer_q <= timer_q + 1'b1;
            end
        end
    end

    // trace packer: marker then two or three address bytes
    wire capture = (state_q == TR_IDLE) && forcedFetchValid;
    wire pushOk = tq.inReady;
    wire [7:0] markByte = wide_q ? MARK_ADDR3 : MARK_ADDR2;

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            TR_IDLE: if (forcedFetchValid) state_d = TR_MARK;
            TR_MARK: if (pushOk) state_d = TR_ADR0;
            TR_ADR0: if (pushOk) state_d = TR_ADR1;
            TR_ADR1: begin
                if (pushOk) state_d = wide_q ? TR_ADR2 : TR_IDLE;
            end
            TR_ADR2: if (pushOk) state_d = TR_IDLE;
            default: state_d = TR_IDLE;
        endcase
    end

    // byte offered to the fifo in each state
    assign tq.inValid = (state_q != TR_IDLE);
    assign tq.inData = (state_q == TR_MARK) ? markByte
                     : (state_q == TR_ADR0) ? addr_q[7:0]
                     : (state_q == TR_ADR1) ? addr_q[15:8]
                     : addr_q[23:16];
    assign tq.outReady = traceReady;

    // packer state and captured address
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            state_q <= TR_IDLE;
            addr_q <= '0;
            wide_q <= 1'b0;
        end else begin
            state_q <= state_d;
            if (capture) begin
                addr_q <= forcedFetchAddr;
                wide_q <= cfgAddrWide;
            end
        end
    end

    trace_fifo #(
        .WIDTH(TRACE_WIDTH),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk_sys(clk_sys),
        .reset(reset),
        .s(tq.fifo)
    );

    // outputs straight from flip-flops
    assign hostRdValid = hostRdValid_q;
    assign hostRdData = hostRdData_q;
    assign syncRequest = syncReq_q;
    assign traceValid = tq.outValid;
    assign traceData = tq.outData;

    // helper: cycles since the timer last restarted, config stable
    logic [CW:0] gap_q;
    logic cfgStable_q;
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            gap_q <= '0;
            cfgStable_q <= 1'b0;
        end else begin
            gap_q <= (expiry || enableRise) ? '0 : gap_q + 1'b1;
            cfgStable_q <= (expiry || enableRise) ? 1'b1
                         : cfgStable_q && syncEnable
                           && (debug_extended_control_status_d == debug_extended_control_status_q)
                           && (debug_config_status_second_d[DEBUG_CONFIG_STATUS_SECOND_DIV16_BIT] == syncDiv16);
        end
    end

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (reset);

    sequence s_request;
        syncReq_q;
    endsequence

    // checked at the expiry cycle, where the gap counter still runs
    property p_fast_period;
        expiry && cfgStable_q && syncDiv16
            |-> (gap_q + 1'b1 == periodOf(1'b1, syncSel));
    endproperty
    a_fast_period: assert property (p_fast_period)
        else $error("fast sync period wrong");

    property p_slow_period;
        expiry && cfgStable_q && !syncDiv16
            |-> (gap_q + 1'b1 == periodOf(1'b0, syncSel));
    endproperty
    a_slow_period: assert property (p_slow_period)
        else $error("slow sync period wrong");

    property p_disabled_quiet;
        !syncEnable ##1 !syncEnable |-> !syncReq_q;
    endproperty
    a_disabled_quiet: assert property (p_disabled_quiet)
        else $error("sync request while disabled");

    property p_expiry_request;
        (syncEnable && timer_q == period - 1'b1 && enablePrev_q)
            |=> s_request ##1 !syncReq_q;
    endproperty
    a_expiry_request: assert property (p_expiry_request)
        else $error("expiry did not give one request");

    sequence s_short_tail;
        state_q == TR_ADR1 && !wide_q && pushOk;
    endsequence
    property p_two_byte;
        s_short_tail |=> state_q == TR_IDLE;
    endproperty
    a_two_byte: assert property (p_two_byte)
        else $error("two-byte address ran long");

    property p_marker_first;
        capture |=> tq.inValid && tq.inData == $past(
            cfgAddrWide ? MARK_ADDR3 : MARK_ADDR2);
    endproperty
    a_marker_first: assert property (p_marker_first)
        else $error("marker not offered first");

    property p_byte_read;
        byteRead |=> hostRdValid && hostRdData[31:8] == 24'h00_0000
            && hostRdData[7:0] == $past(debug_config_status_second_q[31:24]);
    endproperty
    a_byte_read: assert property (p_byte_read)
        else $error("top byte read wrong");

    property p_byte_write;
        byteWrite && !coreWrite |=> debug_config_status_second_q[23:0] == $past(debug_config_status_second_q[23:0]);
    endproperty
    a_byte_write: assert property (p_byte_write)
        else $error("byte write touched low bits");

    property p_dreg_read;
        dregRead && isCsr2 |=> hostRdData == $past(debug_config_status_second_q);
    endproperty
    a_dreg_read: assert property (p_dreg_read)
        else $error("register read wrong");

    property p_user_write;
        coreDebugWrite && !coreSupervisor && !hostCmdValid
            |=> debug_config_status_second_q == $past(debug_config_status_second_q);
    endproperty
    a_user_write: assert property (p_user_write)
        else $error("user-mode write took effect");

    property p_restart;
        enableRise |=> timer_q == '0;
    endproperty
    a_restart: assert property (p_restart)
        else $error("timer not restarted");
endmodule

// ---- dv/debug_host_model.sv ----
// debug host model driving the background debug command port
module debug_host_model
    import dbg_sync_pkg::*;
(
    input wire logic clk_sys,
    output logic hostCmdValid,
    output dbg_sync_pkg::host_cmd_t hostCmd,
    output dbg_sync_pkg::reg_sel_t hostRegSel,
    output logic [31:0] hostWrData
);
    timeunit 1ns;
    timeprecision 1ns;
    // idle port after power-up
    initial begin
        hostCmdValid = 1'b0;
        hostCmd = CMD_NONE;
        hostRegSel = REG_DEBUG_EXTENDED_CONTROL_STATUS;
        hostWrData = 32'h0;
    end
    // one command held over a single edge, then data inverted
    task automatic send(input host_cmd_t c, input reg_sel_t s,
                        input logic [31:0] d);
        @(posedge clk_sys);
        #1;
        hostCmdValid = 1'b1;
        hostCmd = c;
        hostRegSel = s;
        hostWrData = d;
        @(posedge clk_sys);
        #1;
        hostCmdValid = 1'b0;
        hostCmd = CMD_NONE;
        hostWrData = ~d;
    endtask
endmodule

// ---- dv/tb_debug_pc_sync.sv ----
// self-checking bench for the pc-sync block
module tb_debug_pc_sync;
    import dbg_sync_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_sys = 0, reset = 1, hostRdValid, syncRequest, traceValid;
    logic coreDebugWrite = 0, coreSupervisor = 0, cfgAddrWide = 0;
    logic forcedFetchValid = 0, traceReady = 0, respond = 0;
    logic [31:0] hostRdData, coreWrData = 0, rs = 32'h3308AF62;
    logic [31:0] xcsrM = DEBUG_EXTENDED_CONTROL_STATUS_RESET, csr2M = DEBUG_CONFIG_STATUS_SECOND_RESET;
    logic [23:0] forcedFetchAddr = 0;
    logic [7:0] traceData;
    logic hostCmdValid;
    host_cmd_t hostCmd;
    reg_sel_t hostRegSel;
    logic [31:0] hostWrData;
    logic [31:0] rdQ[$];
    logic [7:0] trQ[$];
    int errCount = 0, nCompared = 0, cyc = 0, t0, k;
    always #50 clk_sys = ~clk_sys;
    always @(posedge clk_sys) cyc <= cyc + 1;
    debug_host_model host (.clk_sys(clk_sys), .hostCmdValid(hostCmdValid),
        .hostCmd(hostCmd), .hostRegSel(hostRegSel), .hostWrData(hostWrData));
    debug_pc_sync #(.FAST_BASE(8), .SLOW_BASE(16)) uut (.clk_sys(clk_sys),
        .reset(reset), .hostCmdValid(hostCmdValid), .hostCmd(hostCmd),
        .hostRegSel(hostRegSel), .hostWrData(hostWrData),
        .hostRdValid(hostRdValid), .hostRdData(hostRdData),
        .coreDebugWrite(coreDebugWrite), .coreSupervisor(coreSupervisor),
        .coreWrData(coreWrData), .cfgAddrWide(cfgAddrWide),
        .syncRequest(syncRequest), .forcedFetchValid(forcedFetchValid),
        .forcedFetchAddr(forcedFetchAddr), .traceValid(traceValid),
        .traceData(traceData), .traceReady(traceReady));
    task automatic chk(input string nm, input logic [31:0] e, s);
        nCompared++;
        if (e !== s) begin
            errCount++;
            $display("Error %s expected %h seen %h", nm, e, s);
        end
    endtask
    function automatic logic [31:0] lfsr(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    task automatic rnd();
        rs = lfsr(rs);
    endtask
    task automatic wr(input reg_sel_t s, input logic [31:0] d);
        if (s == REG_DEBUG_CONFIG_STATUS_SECOND) csr2M = d & DEBUG_CONFIG_STATUS_SECOND_HOST_MASK;
        else xcsrM = d & DEBUG_EXTENDED_CONTROL_STATUS_WRITE_MASK;
        host.send(CMD_WRITE_DEBUG_REGISTER_CMD, s, d);
    endtask
    task automatic rd(input host_cmd_t c, input reg_sel_t s);
        rdQ.push_back(c == CMD_READ_TOP_BYTE ? {24'h0, csr2M[31:24]}
            : (s == REG_DEBUG_CONFIG_STATUS_SECOND ? csr2M : xcsrM));
        host.send(c, s, 32'h0);
    endtask
    // one forced fetch from the core; marker then low byte first
    task automatic fetch(input logic wide);
        rnd();
        @(posedge clk_sys);
        #1;
        forcedFetchValid = 1'b1;
        forcedFetchAddr = rs[23:0];
        cfgAddrWide = wide;
        trQ.push_back(wide ? MARK_ADDR3 : MARK_ADDR2);
        trQ.push_back(rs[7:0]);
        trQ.push_back(rs[15:8]);
        if (wide) trQ.push_back(rs[23:16]);
        @(posedge clk_sys);
        #1;
        forcedFetchValid = 1'b0;
    endtask
    // steps at least one edge, samples the pulse once it has settled
    task automatic waitSync();
        int i;
        i = 0;
        do begin
            @(posedge clk_sys);
            #1;
            i++;
        end while (syncRequest !== 1'b1 && i < 20000);
    endtask
    task automatic summarize();
        $display("compared %0d errors %0d", nCompared, errCount);
        if (errCount == 0 && nCompared > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // result watcher: pops the oldest note on each answer
    always @(posedge clk_sys) begin
        if (hostRdValid === 1'b1 && rdQ.size() > 0)
            chk("hostRdData", rdQ.pop_front(), hostRdData);
        if (traceValid === 1'b1 && traceReady === 1'b1 && trQ.size() > 0)
            chk("traceData", trQ.pop_front(), traceData);
    end
    // core stand-in: forced fetch answering each sync request
    always @(posedge clk_sys) begin
        if (respond && syncRequest === 1'b1) begin
            nCompared++;
            fetch(rs[0]);
        end
    end
    initial begin
        #5000000;
        errCount++;
        summarize();
    end
    initial begin
        repeat (8) @(posedge clk_sys);
        #1;
        reset = 0;
        rd(CMD_READ_DEBUG_REGISTER_CMD, REG_DEBUG_EXTENDED_CONTROL_STATUS);
        rd(CMD_READ_DEBUG_REGISTER_CMD, REG_DEBUG_CONFIG_STATUS_SECOND);
        rnd();
        wr(REG_DEBUG_CONFIG_STATUS_SECOND, rs | 32'hFF000000);
        rd(CMD_READ_DEBUG_REGISTER_CMD, REG_DEBUG_CONFIG_STATUS_SECOND);
        rd(CMD_READ_TOP_BYTE, REG_DEBUG_EXTENDED_CONTROL_STATUS);
        csr2M[31:24] = 8'h00;
        host.send(CMD_WRITE_TOP_BYTE, REG_DEBUG_EXTENDED_CONTROL_STATUS, 32'hFFFFFF00);
        rd(CMD_READ_DEBUG_REGISTER_CMD, REG_DEBUG_CONFIG_STATUS_SECOND);
        for (k = 0; k < 2; k++) begin
            rnd();
            @(posedge clk_sys);
            #1;
            coreDebugWrite = 1;
            coreSupervisor = k[0];
            coreWrData = rs;
            if (k == 1) csr2M[23:0] = rs[23:0];
            @(posedge clk_sys);
            #1;
            coreDebugWrite = 0;
            rd(CMD_READ_DEBUG_REGISTER_CMD, REG_DEBUG_CONFIG_STATUS_SECOND);
        end
        for (k = 0; k < 8; k++) begin
            wr(REG_DEBUG_CONFIG_STATUS_SECOND, {25'h0, k[2], 6'h0});
            wr(REG_DEBUG_EXTENDED_CONTROL_STATUS, {29'h0, k[1:0], 1'b1});
            waitSync();
            t0 = cyc;
            waitSync();
            t0 = cyc - t0;
            chk("period", (k[2] ? 8 : 16) << k[1:0], t0);
        end
        wr(REG_DEBUG_EXTENDED_CONTROL_STATUS, 32'h0);
        t0 = 0;
        repeat (300) @(posedge clk_sys) t0 += syncRequest;
        chk("pulses", 0, t0);
        repeat (4) begin
            fetch(1'b1);
            repeat (5) @(posedge clk_sys);
        end
        repeat (10) @(posedge clk_sys);
        chk("fullValid", 1, traceValid);
        for (k = 0; k < 2000 && trQ.size() > 0; k++) begin
            @(posedge clk_sys);
            #1;
            rnd();
            traceReady = rs[0];
            if (k == 3) fetch(1'b0);
        end
        traceReady = 1;
        respond = 1;
        wr(REG_DEBUG_EXTENDED_CONTROL_STATUS, 32'h7);
        repeat (700) @(posedge clk_sys);
        respond = 0;
        wr(REG_DEBUG_EXTENDED_CONTROL_STATUS, 32'h0);
        repeat (20) @(posedge clk_sys);
        chk("traceLeft", 0, trQ.size());
        chk("readsLeft", 0, rdQ.size());
        summarize();
    end
endmodule
